// File: rtl/bus_sequencer.sv
/*
 * Bus cycle sequencer for indexed and inherent mode instructions.
 * Assumes the core presents a class code with a start pulse, and the
 * offset byte (read in cycle 2) on OFFSET during cycle 3.
 */
// How it works
// - indexed: offset at opcode+1, dummy FFFF
// - alu/store 4 cycles, 16-bit 5 cycles
// - indexed read-modify-write takes six cycles
// - test memory: dummy FFFF replaces write
// - compare/double ops: high, low, dummy
// - indexed call: fetch, push return bytes
// - register inherent ops take two reads
// - index/shift ops: three cycles, dummy FFFF
// - stack adjust: dummy read at old pointer
// - push accumulator writes at stack pointer
// - pop accumulator: dummy, then read pointer+1
// - push index: low at sp, high sp-1
// - pop index: dummy, reads sp+1, sp+2
// - cycle one always reads the opcode
`timescale 1ns/1ps
`default_nettype none

module bus_sequencer
   import seq_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic START,
   input wire logic [3:0] INSTR_CLASS,
   input wire logic [15:0] OPCODE_ADDR,
   input wire logic [15:0] XREG,
   input wire logic [15:0] SP,
   input wire logic [7:0] OFFSET,
   output logic [15:0] ADDR,
   output logic RW,
   output logic [3:0] DATA_KIND,
   output logic [3:0] CYCLE,
   output logic BUSY,
   output logic LAST
);

   // ***************************************************
   // cycle count and bus cycle decode
   // ***************************************************
   // bus cycles per instruction class
   function automatic logic [3:0] cycle_count(input class_t c);
      case (c)
         CL_JUMP_IX: cycle_count = LEN_THREE;
         CL_ALU_IX, CL_STORE_ACC_IX: cycle_count = LEN_FOUR;
         CL_LOAD16_IX, CL_STORE16_IX: cycle_count = LEN_FIVE;
         CL_RMW_IX, CL_TEST_IX: cycle_count = LEN_SIX;
         CL_DOUBLE_RD_IX, CL_CALL_IX: cycle_count = LEN_SIX;
         CL_INH_REG: cycle_count = LEN_TWO;
         CL_INH_IDLE3, CL_INH_STACK3: cycle_count = LEN_THREE;
         CL_PUSH_ACC: cycle_count = LEN_THREE;
         CL_POP_ACC, CL_PUSH_XREG: cycle_count = LEN_FOUR;
         CL_POP_XREG: cycle_count = LEN_FIVE;
         default: cycle_count = LEN_TWO;
      endcase
   endfunction

   // returns {address, read/write, data kind}
   function automatic logic [20:0] bus_cycle(
      input class_t c,
      input logic [3:0] n,
      input logic [15:0] opa,
      input logic [15:0] x,
      input logic [7:0] off,
      input logic [15:0] sp
   );
      logic [15:0] ea;
      logic indexed;
      // unsigned offset, sum wraps at 16 bits
      ea = x + {8'h00, off};
      // classes up to the call are indexed
      indexed = (c <= CL_CALL_IX);
      bus_cycle = {ADDR_DUMMY, RW_READ, DK_DUMMY};
      if (n == CYC_FIRST)
      begin
         bus_cycle = {opa, RW_READ, DK_OPCODE};
      end
      else if (n == 4'h2)
      begin
         if (indexed)
         begin
            bus_cycle = {opa + ONE16, RW_READ, DK_OFFSET};
         end
         else if (c == CL_INH_REG || c == CL_INH_STACK3 ||
                  c == CL_PUSH_ACC || c == CL_POP_ACC)
         begin
            bus_cycle = {opa + ONE16, RW_READ, DK_NEXT_OPCODE};
         end
         else
         begin
            bus_cycle = {opa + ONE16, RW_READ, DK_IRRELEVANT};
         end
      end
      else if (n == 4'h3)
      begin
         case (c)
            CL_INH_STACK3, CL_POP_ACC, CL_POP_XREG:
               bus_cycle = {sp, RW_READ, DK_IRRELEVANT};
            CL_PUSH_ACC:
               bus_cycle = {sp, RW_WRITE, DK_OPERAND_WR};
            CL_PUSH_XREG:
               bus_cycle = {sp, RW_WRITE, DK_LOW_WR};
            default:
               bus_cycle = {ADDR_DUMMY, RW_READ, DK_DUMMY};
         endcase
      end
      else if (n == 4'h4)
      begin
         case (c)
            CL_ALU_IX, CL_RMW_IX, CL_TEST_IX:
               bus_cycle = {ea, RW_READ, DK_OPERAND_RD};
            CL_STORE_ACC_IX:
               bus_cycle = {ea, RW_WRITE, DK_OPERAND_WR};
            CL_LOAD16_IX, CL_DOUBLE_RD_IX:
               bus_cycle = {ea, RW_READ, DK_HIGH_RD};
            CL_STORE16_IX:
               bus_cycle = {ea, RW_WRITE, DK_HIGH_WR};
            CL_CALL_IX:
               bus_cycle = {ea, RW_READ, DK_SUB_OPCODE};
            CL_POP_ACC:
               bus_cycle = {sp + ONE16, RW_READ, DK_OPERAND_RD};
            CL_PUSH_XREG:
               bus_cycle = {sp - ONE16, RW_WRITE, DK_HIGH_WR};
            CL_POP_XREG:
               bus_cycle = {sp + ONE16, RW_READ, DK_LOW_RD};
            default:
               bus_cycle = {ADDR_DUMMY, RW_READ, DK_DUMMY};
         endcase
      end
      else if (n == 4'h5)
      begin
         case (c)
            CL_LOAD16_IX, CL_DOUBLE_RD_IX:
               bus_cycle = {ea + ONE16, RW_READ, DK_LOW_RD};
            CL_STORE16_IX:
               bus_cycle = {ea + ONE16, RW_WRITE, DK_LOW_WR};
            CL_CALL_IX:
               bus_cycle = {sp, RW_WRITE, DK_LOW_WR};
            CL_POP_XREG:
               bus_cycle = {sp + TWO16, RW_READ, DK_HIGH_RD};
            default:
               bus_cycle = {ADDR_DUMMY, RW_READ, DK_DUMMY};
         endcase
      end
      else if (n == 4'h6)
      begin
         case (c)
            CL_RMW_IX:
               bus_cycle = {ea, RW_WRITE, DK_OPERAND_WR};
            CL_CALL_IX:
               bus_cycle = {sp - ONE16, RW_WRITE, DK_HIGH_WR};
            default:
               bus_cycle = {ADDR_DUMMY, RW_READ, DK_DUMMY};
         endcase
      end
   endfunction

   // ***************************************************
   // state
   // ***************************************************
   state_t state_reg, state_next;
   class_t class_reg, class_next;
   logic [3:0] cyc_reg, cyc_next;
   logic [15:0] opa_reg, opa_next;
   logic [15:0] x_reg, x_next;
   logic [15:0] sp_reg, sp_next;
   logic [7:0] off_reg, off_next;
   logic [15:0] addr_reg, addr_next;
   logic rw_reg, rw_next;
   logic [3:0] kind_reg, kind_next;
   logic busy_reg, busy_next;
   logic last_reg, last_next;
   logic [20:0] info;
   logic accept;

   always_comb
   begin
      state_next = state_reg;
      class_next = class_reg;
      cyc_next = cyc_reg;
      opa_next = opa_reg;
      x_next = x_reg;
      sp_next = sp_reg;
      off_next = off_reg;
      // a new instruction may follow directly in the last cycle
      accept = START && (state_reg == ST_IDLE || last_reg);
      // offset byte from the core is valid during cycle 3
      if (state_reg == ST_RUN && cyc_reg == CYC_OFFSET_VALID)
      begin
         off_next = OFFSET;
      end
      if (accept)
      begin
         state_next = ST_RUN;
         class_next = class_t'(INSTR_CLASS);
         cyc_next = CYC_FIRST;
         opa_next = OPCODE_ADDR;
         x_next = XREG;
         sp_next = SP;
      end
      else if (state_reg == ST_RUN)
      begin
         if (last_reg)
         begin
            state_next = ST_IDLE;
            cyc_next = CYC_NONE;
         end
         else
         begin
            cyc_next = cyc_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_reg <= ST_IDLE;
         class_reg <= CL_INH_REG;
         cyc_reg <= CYC_NONE;
         opa_reg <= ADDR_RESET;
         x_reg <= ADDR_RESET;
         sp_reg <= ADDR_RESET;
         off_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         class_reg <= class_next;
         cyc_reg <= cyc_next;
         opa_reg <= opa_next;
         x_reg <= x_next;
         sp_reg <= sp_next;
         off_reg <= off_next;
      end
   end

   // ***************************************************
   // registered bus outputs
   // ***************************************************
   // decoded from the next state so every pin is a flop
   always_comb
   begin
      info = bus_cycle(class_next, cyc_next, opa_next, x_next, off_next,
                       sp_next);
      if (state_next == ST_RUN)
      begin
         addr_next = info[20:5];
         rw_next = info[4];
         kind_next = info[3:0];
         busy_next = 1'b1;
         last_next = (cyc_next == cycle_count(class_next));
      end
      else
      begin
         // idle bus parks on a harmless read of FFFF
         addr_next = ADDR_RESET;
         rw_next = RW_READ;
         kind_next = DK_NONE;
         busy_next = 1'b0;
         last_next = 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         addr_reg <= ADDR_RESET;
         rw_reg <= RW_READ;
         kind_reg <= DK_NONE;
         busy_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         addr_reg <= addr_next;
         rw_reg <= rw_next;
         kind_reg <= kind_next;
         busy_reg <= busy_next;
         last_reg <= last_next;
      end
   end

   assign ADDR = addr_reg;
   assign RW = rw_reg;
   assign DATA_KIND = kind_reg;
   assign CYCLE = cyc_reg;
   assign BUSY = busy_reg;
   assign LAST = last_reg;

endmodule

`default_nettype wire

// File: rtl/seq_pkg.sv
/*
 * Constants and types for the indexed and inherent bus cycle sequencer.
 * Assumes a single 10 MHz clock and one bus transfer per machine cycle.
 */
package seq_pkg;
   localparam logic [15:0] ADDR_DUMMY = 16'hFFFF;
   localparam logic [15:0] ADDR_RESET = 16'hFFFF;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [15:0] TWO16 = 16'h0002;
   localparam logic [3:0] CYC_NONE = 4'h0;
   localparam logic [3:0] CYC_FIRST = 4'h1;
   localparam logic [3:0] CYC_OFFSET_VALID = 4'h3;
   localparam logic [3:0] LEN_TWO = 4'h2;
   localparam logic [3:0] LEN_THREE = 4'h3;
   localparam logic [3:0] LEN_FOUR = 4'h4;
   localparam logic [3:0] LEN_FIVE = 4'h5;
   localparam logic [3:0] LEN_SIX = 4'h6;
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;

   typedef enum logic [3:0] {
      CL_JUMP_IX = 4'h0,
      CL_ALU_IX = 4'h1,
      CL_STORE_ACC_IX = 4'h2,
      CL_LOAD16_IX = 4'h3,
      CL_STORE16_IX = 4'h4,
      CL_RMW_IX = 4'h5,
      CL_TEST_IX = 4'h6,
      CL_DOUBLE_RD_IX = 4'h7,
      CL_CALL_IX = 4'h8,
      CL_INH_REG = 4'h9,
      CL_INH_IDLE3 = 4'hA,
      CL_INH_STACK3 = 4'hB,
      CL_PUSH_ACC = 4'hC,
      CL_POP_ACC = 4'hD,
      CL_PUSH_XREG = 4'hE,
      CL_POP_XREG = 4'hF
   } class_t;

   typedef enum logic [3:0] {
      DK_NONE = 4'h0,
      DK_OPCODE = 4'h1,
      DK_OFFSET = 4'h2,
      DK_DUMMY = 4'h3,
      DK_OPERAND_RD = 4'h4,
      DK_OPERAND_WR = 4'h5,
      DK_HIGH_RD = 4'h6,
      DK_LOW_RD = 4'h7,
      DK_HIGH_WR = 4'h8,
      DK_LOW_WR = 4'h9,
      DK_NEXT_OPCODE = 4'hA,
      DK_IRRELEVANT = 4'hB,
      DK_SUB_OPCODE = 4'hC
   } kind_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } state_t;
endpackage

// File: test/mem_model.sv
/* Memory model on the far side of the bus.
   Assumes address and read/write from the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
   input wire logic [15:0] addr,
   input wire logic rw,
   output logic [7:0] rdata
);
   // reads give an address hash, any cycle is harmless
   always_comb rdata = rw ? addr[7:0] ^ addr[15:8] : 8'hA5;
endmodule
`default_nettype wire

// File: test/seq_checker_assertions.sv
/* Port checker for the bus sequencer.
   Assumes it is bound to bus_sequencer. */
`timescale 1ns/1ps
`default_nettype none
module seq_checker
   import seq_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic START,
   input wire logic [3:0] INSTR_CLASS,
   input wire logic [15:0] OPCODE_ADDR,
   input wire logic [15:0] XREG,
   input wire logic [15:0] SP,
   input wire logic [7:0] OFFSET,
   input wire logic [15:0] ADDR,
   input wire logic RW,
   input wire logic [3:0] DATA_KIND,
   input wire logic [3:0] CYCLE,
   input wire logic BUSY,
   input wire logic LAST
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   wire logic tk = START && (!BUSY || LAST);
   sequence s_open;
      ADDR == $past(OPCODE_ADDR, 2) + 16'h0001 && RW ##1 ADDR == 16'hFFFF;
   endsequence
   sequence s_pushx;
      ADDR == $past(SP, 3) && !RW ##1 ADDR == $past(SP, 4) - 16'h0001 && !RW;
   endsequence
   AST_FIRST: assert property (tk |=> ADDR == $past(OPCODE_ADDR) && RW
      && CYCLE == 4'h1 && DATA_KIND == DK_OPCODE) else $error("first cycle");
   AST_OFFSET: assert property (tk && INSTR_CLASS <= 4'h8 |=> ##1 s_open)
      else $error("offset cycles");
   AST_STORE: assert property (tk && INSTR_CLASS == CL_STORE_ACC_IX
      |=> ##3 !RW && LAST) else $error("store cycle");
   AST_RMW: assert property (tk && INSTR_CLASS == CL_RMW_IX |=> ##5 !RW
      && ADDR == $past(XREG, 6) + {8'h00, $past(OFFSET, 2)} && LAST)
      else $error("modify write");
   AST_TEST: assert property (tk && INSTR_CLASS == CL_TEST_IX
      |=> ##5 RW && ADDR == 16'hFFFF && LAST) else $error("test cycle");
   AST_PUSHX: assert property (tk && INSTR_CLASS == CL_PUSH_XREG
      |=> ##2 s_pushx) else $error("push index");
   AST_IDLE: assert property (!BUSY |-> ADDR == 16'hFFFF && RW
      && CYCLE == 4'h0 && !LAST) else $error("idle values");
   AST_REFUSE: assert property (START && BUSY && !LAST
      |=> CYCLE == $past(CYCLE) + 4'h1) else $error("start not ignored");
endmodule
`default_nettype wire

// File: test/tb_bus_sequencer.sv
/* Self-checking bench for bus_sequencer.
   Assumes seq_pkg, mem_model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_bus_sequencer
   import seq_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [3:0] cls = 4'h0;
   logic [15:0] opa = 16'h0000;
   logic [15:0] xr = 16'h0000;
   logic [15:0] sp = 16'h0000;
   logic [7:0] off = 8'h00;
   logic [15:0] addr;
   logic rw, busy, last;
   logic [3:0] kind, cyc;
   logic [7:0] rdata;
   int failures = 0;
   int cmp_count = 0;
   int nc[16] = '{3, 4, 4, 5, 5, 6, 6, 6, 6, 2, 3, 3, 3, 4, 4, 5};
   always #50 clk = ~clk;
   bus_sequencer uut (.CLK(clk), .RST(rst), .START(start), .INSTR_CLASS(cls),
      .OPCODE_ADDR(opa), .XREG(xr), .SP(sp), .OFFSET(off), .ADDR(addr),
      .RW(rw), .DATA_KIND(kind), .CYCLE(cyc), .BUSY(busy), .LAST(last));
   mem_model mem (.addr(addr), .rw(rw), .rdata(rdata));
   task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wrap_up();
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // expected {addr, rw, kind} from the cycle tables
   function automatic logic [20:0] ex(input logic [3:0] c, input int k,
      input logic [15:0] o, x, s);
      logic [15:0] p, e;
      p = o + 16'h0001;
      e = x + {8'h00, p[7:0] ^ p[15:8]};
      if (k == 1)
         return {o, 1'b1, 4'h1};
      if (k == 2)
         return {p, 1'b1, c < 4'h9 ? 4'h2 : (c == 4'h9 || c == 4'hB ||
            c == 4'hC || c == 4'hD) ? 4'hA : 4'hB};
      if (c < 4'h9)
      begin
         if (k == 3)
            return {16'hFFFF, 1'b1, 4'h3};
         case (c)
            4'h1: return {e, 1'b1, 4'h4};
            4'h2: return {e, 1'b0, 4'h5};
            4'h3: return {e + 16'(k - 4), 1'b1, 4'(k + 2)};
            4'h4: return {e + 16'(k - 4), 1'b0, 4'(k + 4)};
            4'h5, 4'h6: return k == 4 ? {e, 1'b1, 4'h4} : (k == 5 || c == 4'h6)
               ? {16'hFFFF, 1'b1, 4'h3} : {e, 1'b0, 4'h5};
            4'h7: return k == 6 ? {16'hFFFF, 1'b1, 4'h3}
               : {e + 16'(k - 4), 1'b1, 4'(k + 2)};
            default: return k == 4 ? {e, 1'b1, 4'hC}
               : {s - 16'(k - 5), 1'b0, 4'(14 - k)};
         endcase
      end
      case (c)
         4'hA: return {16'hFFFF, 1'b1, 4'h3};
         4'hB: return {s, 1'b1, 4'hB};
         4'hC: return {s, 1'b0, 4'h5};
         4'hE: return {s - 16'(k - 3), 1'b0, 4'(12 - k)};
         4'hD: return {s + 16'(k - 3), 1'b1, k == 3 ? 4'hB : 4'h4};
         default: return {s + 16'(k - 3), 1'b1, k == 3 ? 4'hB : 4'(11 - k)};
      endcase
   endfunction
   task idle_chk();
      cmp("ADDR", 16'hFFFF, addr);
      cmp("RW", 16'h0001, {15'h0000, rw});
      cmp("KIND", 16'h0000, {12'h000, kind});
      cmp("CYCLE", 16'h0000, {12'h000, cyc});
      cmp("BUSY", 16'h0000, {15'h0000, busy});
      cmp("LAST", 16'h0000, {15'h0000, last});
   endtask
   task run(input logic [3:0] c, input logic [15:0] o, x, s,
      input bit iss, rep, poke);
      logic [20:0] e;
      logic [7:0] ob;
      if (iss)
      begin
         @(posedge clk);
         start <= 1'b1;
         cls <= c;
         opa <= o;
         xr <= x;
         sp <= s;
      end
      for (int k = 1; k <= nc[c]; k++)
      begin
         @(posedge clk);
         start <= (k == nc[c] && rep) || (k == 2 && poke);
         if (k == 3)
            off <= ob;
         #1;
         if (k == 2)
            ob = rdata;
         e = ex(c, k, o, x, s);
         cmp("ADDR", e[20:5], addr);
         cmp("RW", {15'h0000, e[4]}, {15'h0000, rw});
         cmp("KIND", {12'h000, e[3:0]}, {12'h000, kind});
         cmp("BUSY", 16'h0001, {15'h0000, busy});
         cmp("CYCLE", 16'(k), {12'h000, cyc});
         cmp("LAST", {15'h0000, k == nc[c]}, {15'h0000, last});
      end
      if (!rep)
      begin
         @(posedge clk);
         #1;
         idle_chk();
      end
   endtask
   task t_classes();
      for (int c = 0; c < 16; c++)
         run(4'(c), 16'h2100 + 16'(c), 16'h4000, 16'h01F0, 1, 0, 0);
   endtask
   task t_wrap();
      run(CL_LOAD16_IX, 16'h00FE, 16'hFF01, 16'h0000, 1, 0, 0);
      run(CL_CALL_IX, 16'h00FE, 16'hFF01, 16'h0000, 1, 0, 0);
   endtask
   task t_b2b();
      run(CL_INH_REG, 16'h3000, 16'h0000, 16'h0100, 1, 1, 0);
      run(CL_INH_REG, 16'h3000, 16'h0000, 16'h0100, 0, 0, 0);
   endtask
   task t_refuse();
      run(CL_RMW_IX, 16'h5000, 16'h6000, 16'h0100, 1, 0, 1);
   endtask
   task t_reset();
      @(posedge clk);
      start <= 1'b1;
      cls <= CL_PUSH_XREG;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1;
      idle_chk();
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      idle_chk();
      t_classes();
      t_wrap();
      t_b2b();
      t_refuse();
      t_reset();
      t_b2b();
      wrap_up();
   end
   initial
   begin
      #1000000;
      failures++;
      wrap_up();
   end
endmodule
bind bus_sequencer seq_checker chk (.CLK(CLK), .RST(RST), .START(START),
   .INSTR_CLASS(INSTR_CLASS), .OPCODE_ADDR(OPCODE_ADDR), .XREG(XREG),
   .SP(SP), .OFFSET(OFFSET), .ADDR(ADDR), .RW(RW), .DATA_KIND(DATA_KIND),
   .CYCLE(CYCLE), .BUSY(BUSY), .LAST(LAST));
`default_nettype wire
